/* File: hdl/crr_pkg.sv */
package crr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [8:0] CRR_IDX_CTRL = 9'h170;
  localparam logic [8:0] CRR_IDX_LOC = 9'h180;
  localparam logic [8:0] CRR_IDX_AMP = 9'h185;
  localparam int CRR_RW_N = 5;
  // Window, shadow, peak threshold, short cable, pulse width
  localparam logic [8:0] CRR_RW_IDX [CRR_RW_N] = '{9'h173, 9'h175, 9'h176, 9'h177, 9'h178};
  localparam int CRR_RSVD_N = 10;
  localparam logic [8:0] CRR_RSVD_IDX [CRR_RSVD_N] = '{9'h171, 9'h172, 9'h174, 9'h181,
    9'h182, 9'h183, 9'h184, 9'h186, 9'h187, 9'h188};

  // ----------------------------------------------------------------
  // Writable bits and values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] CRR_RW_MASK [CRR_RW_N] = '{16'hffff, 16'h380f, 16'h001f,
    16'h1f00, 16'h0007};
  localparam logic [15:0] CRR_RW_RESET [CRR_RW_N] = '{16'h0d04, 16'h1004, 16'h0005,
    16'h1e00, 16'h0002};
  localparam logic [15:0] CRR_CTRL_MASK = 16'h0770;
  localparam logic [15:0] CRR_CTRL_RESET = 16'h0410;

  // ----------------------------------------------------------------
  // Control field positions and legal codes
  // ----------------------------------------------------------------
  localparam int CRR_SEG_LSB = 4;
  localparam int CRR_AVG_LSB = 8;
  localparam logic [2:0] CRR_SEG_MIN = 3'h1;
  localparam logic [2:0] CRR_SEG_MAX = 3'h5;
  localparam logic [2:0] CRR_AVG_RSVD = 3'h7;

  // ----------------------------------------------------------------
  // Bus answers and decode results
  // ----------------------------------------------------------------
  localparam logic [1:0] CRR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CRR_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CRR_SEL_WIN = 4'h0,
    CRR_SEL_SHADOW = 4'h1,
    CRR_SEL_THRESH = 4'h2,
    CRR_SEL_SHORT = 4'h3,
    CRR_SEL_PULSE = 4'h4,
    CRR_SEL_CTRL = 4'h5,
    CRR_SEL_LOC = 4'h6,
    CRR_SEL_AMP = 4'h7,
    CRR_SEL_RSVD = 4'h8,
    CRR_SEL_BAD = 4'h9
  } crr_sel_t;

  // Configuration handed to the reflectometry engine
  typedef struct packed {
    logic [2:0] avg_code;
    logic [2:0] segment;
    logic [7:0] seg_duration;
    logic [7:0] initial_skip;
    logic [2:0] shadow_avg_loc;
    logic [3:0] fwd_shadow;
    logic [4:0] peak_loc_thresh;
    logic [4:0] short_thresh;
    logic [2:0] tx_pulse_width;
  } crr_cfg_t;

endpackage

/* File: hdl/crr_write_join.sv */
`timescale 1ns/1ps
`default_nettype none

module crr_write_join #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Write address channel
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Response taken, frees both channels
  input wire logic release_pulse,
  // Held request
  output logic [AW-1:0] held_addr,
  output logic [31:0] held_data,
  output logic [3:0] held_strb
);

  // ----------------------------------------------------------------
  // Address capture, ready drops while an address is held
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'b1;
      held_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      held_addr <= awaddr;
    end else if (release_pulse) begin
      awready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data capture, independent of address order
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wready <= 1'b1;
      held_data <= 32'h0;
      held_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      held_data <= wdata;
      held_strb <= wstrb;
    end else if (release_pulse) begin
      wready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/crr_result_hold.sv */
`timescale 1ns/1ps
`default_nettype none

module crr_result_hold (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Engine results
  input wire logic result_valid,
  input wire logic [7:0] result_location,
  input wire logic [6:0] result_amplitude,
  // Held results
  output logic [7:0] first_peak_position,
  output logic [6:0] first_peak_height
);

  // ----------------------------------------------------------------
  // Results stay zero until a run finishes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_peak_position <= 8'h0; // RL13
      first_peak_height <= 7'h0; // RL13
    end else if (result_valid) begin
      first_peak_position <= result_location; // RL8
      first_peak_height <= result_amplitude; // RL9
    end
  end

endmodule

`default_nettype wire

/* File: hdl/crr_regs.sv */
// Functional notes
// RL1: Segment duration byte, bits 15-8, reset 0x0d.
// RL2: Software loads per-segment durations 0d/0d/1a/34/8f.
// RL3: Initial skip byte, bits 7-0, read-write.
// RL4: Shadow average location bits 13-11, reset 2.
// RL5: Forward shadow length bits 3-0, read-write.
// RL6: Short cable threshold bits 12-8, reset 0x1e.
// RL7: Transmit pulse width bits 2-0, reset 2.
// RL8: Read-only first peak position, bits 7-0.
// RL9: Read-only first peak height, bits 6-0.
// RL10: Segment select codes 1 to 5 only.
// RL11: Averaging code 0 to 6, 7 refused.
// RL12: Reserved bits read zero, writes ignored.
// RL13: Results zero until a run completes.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module crr_regs #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reflectometry engine results
  input wire logic result_valid,
  input wire logic [7:0] result_location,
  input wire logic [6:0] result_amplitude,
  // Configuration to the engine
  output crr_pkg::crr_cfg_t cfg_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic crr_pkg::crr_sel_t crr_decode(input logic [AW-1:0] addr);
    logic [8:0] idx;
    crr_pkg::crr_sel_t sel;
    idx = addr[10:2];
    sel = crr_pkg::CRR_SEL_BAD;
    if (addr[1:0] == 2'h0 && addr[AW-1:11] == '0) begin
      if (idx == crr_pkg::CRR_IDX_CTRL) begin
        sel = crr_pkg::CRR_SEL_CTRL;
      end
      if (idx == crr_pkg::CRR_IDX_LOC) begin
        sel = crr_pkg::CRR_SEL_LOC;
      end
      if (idx == crr_pkg::CRR_IDX_AMP) begin
        sel = crr_pkg::CRR_SEL_AMP;
      end
      for (int k = 0; k < crr_pkg::CRR_RW_N; k++) begin
        if (idx == crr_pkg::CRR_RW_IDX[k]) begin
          sel = crr_pkg::crr_sel_t'(k[3:0]);
        end
      end
      for (int k = 0; k < crr_pkg::CRR_RSVD_N; k++) begin
        if (idx == crr_pkg::CRR_RSVD_IDX[k]) begin
          sel = crr_pkg::CRR_SEL_RSVD;
        end
      end
    end
    return sel;
  endfunction

  // Byte lanes merged, then reserved bits forced to zero
  function automatic logic [15:0] crr_merge(input logic [15:0] old, input logic [15:0] data,
                                            input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m[15:8] = strb[1] ? data[15:8] : old[15:8];
    m[7:0] = strb[0] ? data[7:0] : old[7:0];
    return m & mask;
  endfunction

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  logic [AW-1:0] held_addr;
  logic [31:0] held_data;
  logic [3:0] held_strb;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic release_pulse;
  logic do_write;
  crr_pkg::crr_sel_t wr_sel;

  crr_write_join #(
    .AW(AW)
  ) u_join (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .release_pulse(release_pulse),
    .held_addr(held_addr),
    .held_data(held_data),
    .held_strb(held_strb)
  );

  // Write fires once both halves are held and no answer is pending
  assign do_write = !s_axi_awready && !s_axi_wready && !bvalid_reg;
  assign release_pulse = bvalid_reg && s_axi_bready;
  assign wr_sel = crr_decode(held_addr);

  // Write response
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= crr_pkg::CRR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == crr_pkg::CRR_SEL_BAD) ? crr_pkg::CRR_RESP_SLVERR :
                   crr_pkg::CRR_RESP_OKAY;
    end else if (release_pulse) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [15:0] rw_reg [crr_pkg::CRR_RW_N];
  logic [15:0] ctrl_reg;

  // Plain read-write registers, reserved bits masked off
  for (genvar i = 0; i < crr_pkg::CRR_RW_N; i++) begin : g_rw
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        rw_reg[i] <= crr_pkg::CRR_RW_RESET[i]; // RL1 RL4 RL6 RL7
      end else if (do_write && wr_sel == 4'(i)) begin
        rw_reg[i] <= crr_merge(rw_reg[i], held_data[15:0], held_strb[1:0],
                               crr_pkg::CRR_RW_MASK[i]); // RL3 RL5 RL12
      end
    end
  end

  // Segment select and averaging, reserved codes leave the field as it was
  logic [2:0] seg_wr;
  logic [2:0] avg_wr;
  assign seg_wr = held_data[crr_pkg::CRR_SEG_LSB +: 3];
  assign avg_wr = held_data[crr_pkg::CRR_AVG_LSB +: 3];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= crr_pkg::CRR_CTRL_RESET;
    end else if (do_write && wr_sel == crr_pkg::CRR_SEL_CTRL) begin
      if (held_strb[0] && seg_wr >= crr_pkg::CRR_SEG_MIN && seg_wr <= crr_pkg::CRR_SEG_MAX) begin
        ctrl_reg[crr_pkg::CRR_SEG_LSB +: 3] <= seg_wr; // RL10
      end
      if (held_strb[1] && avg_wr != crr_pkg::CRR_AVG_RSVD) begin
        ctrl_reg[crr_pkg::CRR_AVG_LSB +: 3] <= avg_wr; // RL11
      end
    end
  end

  // Configuration fields wired straight from the registers
  assign cfg_out.avg_code = ctrl_reg[crr_pkg::CRR_AVG_LSB +: 3];
  assign cfg_out.segment = ctrl_reg[crr_pkg::CRR_SEG_LSB +: 3];
  assign cfg_out.seg_duration = rw_reg[0][15:8]; // RL1
  assign cfg_out.initial_skip = rw_reg[0][7:0]; // RL3
  assign cfg_out.shadow_avg_loc = rw_reg[1][13:11]; // RL4
  assign cfg_out.fwd_shadow = rw_reg[1][3:0]; // RL5
  assign cfg_out.peak_loc_thresh = rw_reg[2][4:0];
  assign cfg_out.short_thresh = rw_reg[3][12:8]; // RL6
  assign cfg_out.tx_pulse_width = rw_reg[4][2:0]; // RL7

  // ----------------------------------------------------------------
  // Results from the engine
  // ----------------------------------------------------------------
  logic [7:0] first_peak_position;
  logic [6:0] first_peak_height;

  crr_result_hold u_hold (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .result_valid(result_valid),
    .result_location(result_location),
    .result_amplitude(result_amplitude),
    .first_peak_position(first_peak_position),
    .first_peak_height(first_peak_height)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  crr_pkg::crr_sel_t rd_sel;
  logic [15:0] rd_word;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  assign rd_sel = crr_decode(s_axi_araddr);

  // Read mux, reserved and unmapped words give zero
  always_comb begin
    rd_word = 16'h0;
    case (rd_sel)
      crr_pkg::CRR_SEL_WIN: rd_word = rw_reg[0];
      crr_pkg::CRR_SEL_SHADOW: rd_word = rw_reg[1];
      crr_pkg::CRR_SEL_THRESH: rd_word = rw_reg[2];
      crr_pkg::CRR_SEL_SHORT: rd_word = rw_reg[3];
      crr_pkg::CRR_SEL_PULSE: rd_word = rw_reg[4];
      crr_pkg::CRR_SEL_CTRL: rd_word = ctrl_reg;
      crr_pkg::CRR_SEL_LOC: rd_word = {8'h0, first_peak_position}; // RL8
      crr_pkg::CRR_SEL_AMP: rd_word = {9'h0, first_peak_height}; // RL9
      default: rd_word = 16'h0; // RL12
    endcase
  end

  // Address taken, data answered one cycle later
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= crr_pkg::CRR_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0, rd_word};
      rresp_reg <= (rd_sel == crr_pkg::CRR_SEL_BAD) ? crr_pkg::CRR_RESP_SLVERR :
                   crr_pkg::CRR_RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_duration_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
    (do_write && wr_sel == crr_pkg::CRR_SEL_WIN && held_strb[1])
    |=> cfg_out.seg_duration == $past(held_data[15:8]))
    else $error("segment duration not written");

  a_skip_lane_keep: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    (do_write && wr_sel == crr_pkg::CRR_SEL_WIN && !held_strb[0])
    |=> $stable(cfg_out.initial_skip))
    else $error("initial skip changed without its byte lane");

  a_avg_loc_reset: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    $rose(reset_n) |-> cfg_out.shadow_avg_loc == 3'h2 && cfg_out.seg_duration == 8'h0d)
    else $error("shadow location or duration wrong after reset");

  a_shadow_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    (do_write && wr_sel == crr_pkg::CRR_SEL_SHADOW && held_strb[0])
    |=> cfg_out.fwd_shadow == $past(held_data[3:0]) && rw_reg[1][10:4] == 7'h0)
    else $error("forward shadow write wrong");

  a_short_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
    (do_write && wr_sel == crr_pkg::CRR_SEL_SHORT && held_strb[1])
    |=> cfg_out.short_thresh == $past(held_data[12:8]) && rw_reg[3][7:0] == 8'h0)
    else $error("short cable threshold write wrong");

  a_pulse_reset: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL7
    $rose(reset_n) |-> cfg_out.tx_pulse_width == 3'h2 && cfg_out.short_thresh == 5'h1e)
    else $error("pulse width or threshold wrong after reset");

  a_location_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    (s_axi_arvalid && s_axi_arready && rd_sel == crr_pkg::CRR_SEL_LOC)
    |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(first_peak_position)})
    else $error("peak position read wrong");

  a_height_capture: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL9
    result_valid |=> first_peak_height == $past(result_amplitude) &&
    first_peak_position == $past(result_location))
    else $error("results not captured");

  a_segment_legal: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    cfg_out.segment >= 3'h1 && cfg_out.segment <= 3'h5)
    else $error("segment select holds a reserved code");

  a_avg_legal: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
    (do_write && wr_sel == crr_pkg::CRR_SEL_CTRL && held_strb[1] && avg_wr == 3'h7)
    |=> $stable(cfg_out.avg_code))
    else $error("reserved averaging code taken");

  a_reserved_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL12
    (s_axi_arvalid && s_axi_arready && rd_sel == crr_pkg::CRR_SEL_RSVD)
    |=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
    else $error("reserved register read not zero");

  a_result_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL13
    !result_valid |=> $stable(first_peak_position) && $stable(first_peak_height))
    else $error("results changed without a run");

endmodule

`default_nettype wire

/* File: tb/crr_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic clk_sys;
  logic reset_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic result_valid;
  logic [7:0] result_location;
  logic [6:0] result_amplitude;
  crr_pkg::crr_cfg_t cfg_out;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 84371;
  // Window, shadow, threshold, short cable, pulse width, control
  logic [8:0] rw_idx [6] = '{9'h173, 9'h175, 9'h176, 9'h177, 9'h178, 9'h170};
  logic [15:0] rw_mask [6] = '{16'hffff, 16'h380f, 16'h001f, 16'h1f00, 16'h0007, 16'h0770};
  logic [15:0] rw_rst [6] = '{16'h0d04, 16'h1004, 16'h0005, 16'h1e00, 16'h0002, 16'h0410};
  logic [8:0] rsvd_idx [10] = '{9'h171, 9'h172, 9'h174, 9'h181, 9'h182, 9'h183, 9'h184,
    9'h186, 9'h187, 9'h188};
  logic [8:0] bad_idx [4] = '{9'h179, 9'h17f, 9'h189, 9'h000};
  logic [15:0] mdl [6];
  logic [7:0] res_loc;
  logic [6:0] res_amp;
  // Recommended per-segment settings
  logic [7:0] dur [5] = '{8'h0d, 8'h0d, 8'h1a, 8'h34, 8'h8f};
  logic [7:0] skip [5] = '{8'h07, 8'h14, 8'h21, 8'h3b, 8'h6f};
  logic [3:0] fwd [5] = '{4'h4, 4'h4, 4'h5, 4'h8, 4'hb};
  logic [2:0] pw [5] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h6};

  crr_regs #(.AW(12)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .result_valid(result_valid),
    .result_location(result_location), .result_amplitude(result_amplitude), .cfg_out(cfg_out)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Cut a hung run short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Reporting and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Register value after a write, reserved codes kept out
  function automatic logic [15:0] apply(input int i, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic [15:0] n;
    m = rw_mask[i] & {{8{s[1]}}, {8{s[0]}}};
    n = (mdl[i] & ~m) | (d & m);
    if (i == 5 && (n[6:4] < 3'h1 || n[6:4] > 3'h5)) n[6:4] = mdl[i][6:4];
    if (i == 5 && n[10:8] == 3'h7) n[10:8] = mdl[i][10:8];
    return n;
  endfunction

  // Configuration the engine should see
  function automatic crr_pkg::crr_cfg_t exp_cfg();
    crr_pkg::crr_cfg_t c;
    c.avg_code = mdl[5][10:8];
    c.segment = mdl[5][6:4];
    c.seg_duration = mdl[0][15:8];
    c.initial_skip = mdl[0][7:0];
    c.shadow_avg_loc = mdl[1][13:11];
    c.fwd_shadow = mdl[1][3:0];
    c.peak_loc_thresh = mdl[2][4:0];
    c.short_thresh = mdl[3][12:8];
    c.tx_pulse_width = mdl[4][2:0];
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [8:0] idx, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] off, output logic [1:0] resp);
    logic aw_ok, w_ok, ta, tw;
    @(posedge clk_sys);
    s_axi_awaddr <= {1'b0, idx, off};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys);
      ta = !aw_ok && s_axi_awready === 1'b1;
      tw = !w_ok && s_axi_wready === 1'b1;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw_ok = aw_ok | ta;
      w_ok = w_ok | tw;
    end
    s_axi_bready <= 1'b1;
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [8:0] idx, input logic [1:0] off, input logic [15:0] exp,
                        input logic [1:0] exp_resp);
    @(posedge clk_sys);
    s_axi_araddr <= {1'b0, idx, off};
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    check(48'(s_axi_rdata), {32'h0, exp}, "read data");
    check(48'(s_axi_rresp), 48'(exp_resp), "read response");
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask

  // Write one writable register, then read it back and look at the engine side
  task automatic do_rw(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_write(rw_idx[i], d, s, 2'h0, r);
    check(48'(r), 48'(crr_pkg::CRR_RESP_OKAY), "write response");
    mdl[i] = apply(i, d[15:0], s);
    check(48'(cfg_out), 48'(exp_cfg()), "config after write");
    rd_chk(rw_idx[i], 2'h0, mdl[i], crr_pkg::CRR_RESP_OKAY);
  endtask

  task automatic pulse(input logic [7:0] loc, input logic [6:0] amp);
    @(posedge clk_sys);
    result_valid <= 1'b1;
    result_location <= loc;
    result_amplitude <= amp;
    res_loc = loc;
    res_amp = amp;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [1:0] r;
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {result_valid, result_location, result_amplitude} = '0;
    res_loc = 8'h0;
    res_amp = 7'h0;
    for (int i = 0; i < 6; i++) mdl[i] = rw_rst[i];
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Values after reset, results cleared
    check(48'(cfg_out), 48'(exp_cfg()), "config after reset");
    for (int i = 0; i < 6; i++) rd_chk(rw_idx[i], 2'h0, rw_rst[i], 2'h0);
    rd_chk(9'h180, 2'h0, 16'h0, 2'h0);
    rd_chk(9'h185, 2'h0, 16'h0, 2'h0);
    $display("test reset_values done");
    // Recommended per-segment settings
    for (int s = 0; s < 5; s++) begin
      do_rw(0, {16'hffff, dur[s], skip[s]}, 4'hf);
      do_rw(1, {16'h0, 5'h1a, 7'h7f, fwd[s]}, 4'h3);
      do_rw(4, {29'h0, pw[s]}, 4'h1);
      do_rw(5, {16'h0, 8'h04, 1'b0, 3'(s + 1), 4'h0}, 4'h3);
      check(48'(cfg_out.seg_duration), 48'(dur[s]), "segment duration");
      check(48'(cfg_out.shadow_avg_loc), 48'h2, "shadow location");
    end
    $display("test segment_table done");
    // Every segment select and averaging code, reserved ones kept out
    for (int c = 0; c < 8; c++) begin
      do_rw(5, {16'h0, 5'h0, 3'(c), 1'b0, 3'(c), 4'hf}, 4'h1);
      do_rw(5, {16'h0, 5'h0, 3'(c), 8'hff}, 4'h2);
    end
    $display("test control_codes done");
    // Random writes with random byte strobes
    for (int n = 0; n < 40; n++) begin
      do_rw($unsigned($random(seed)) % 6, $random(seed), $random(seed));
    end
    $display("test random_rw done");
    // Engine results, back to back and spaced
    for (int n = 0; n < 6; n++) begin
      pulse($random(seed), $random(seed));
      if (n % 2 == 1) begin
        @(posedge clk_sys);
        result_valid <= 1'b0;
        result_location <= ~res_loc;
        result_amplitude <= ~res_amp;
        rd_chk(9'h180, 2'h0, {8'h0, res_loc}, 2'h0);
        rd_chk(9'h185, 2'h0, {9'h0, res_amp}, 2'h0);
      end
    end
    $display("test results done");
    // Reserved and read-only places ignore writes
    for (int i = 0; i < 10; i++) begin
      axi_write(rsvd_idx[i], 32'hffffffff, 4'hf, 2'h0, r);
      check(48'(r), 48'(crr_pkg::CRR_RESP_OKAY), "reserved write");
      rd_chk(rsvd_idx[i], 2'h0, 16'h0, 2'h0);
    end
    axi_write(9'h180, 32'hffffffff, 4'hf, 2'h0, r);
    check(48'(r), 48'(crr_pkg::CRR_RESP_OKAY), "read-only write");
    axi_write(9'h185, 32'hffffffff, 4'hf, 2'h0, r);
    check(48'(r), 48'(crr_pkg::CRR_RESP_OKAY), "read-only write");
    rd_chk(9'h180, 2'h0, {8'h0, res_loc}, 2'h0);
    rd_chk(9'h185, 2'h0, {9'h0, res_amp}, 2'h0);
    check(48'(cfg_out), 48'(exp_cfg()), "config after reserved writes");
    $display("test reserved done");
    // Unmapped and misaligned addresses answer with an error
    for (int i = 0; i < 5; i++) begin
      axi_write(i < 4 ? bad_idx[i] : 9'h173, 32'h0, 4'hf, i < 4 ? 2'h0 : 2'h2, r);
      check(48'(r), 48'(crr_pkg::CRR_RESP_SLVERR), "unmapped write");
      rd_chk(i < 4 ? bad_idx[i] : 9'h173, i < 4 ? 2'h0 : 2'h1, 16'h0, crr_pkg::CRR_RESP_SLVERR);
    end
    check(48'(cfg_out), 48'(exp_cfg()), "config after unmapped writes");
    $display("test unmapped done");
    print_verdict();
  end
endmodule

`default_nettype wire
